// ---- hdl/bst_tap.sv ----
// bst_tap: boundary-scan test port, instruction decode, boundary register, bypass, apb control.
// assumes: tck/tms/tdi/reprogram_pin/pads are asynchronous pins; tck is well below mclk/4.
// Behaviour
// - three-bit instruction register decoding eight codes via the instruction path
// - code 000 external test: pad driven from register or input captured per tristate bit
// - codes 001 and 101 route two separate internal logic scan chains
// - code 010 routes test data input to the configuration write path
// - code 110 presents readback data on test output after configuration
// - code 100 samples every pad level and tristate control together
// - code 111 puts one bypass flip-flop between data input and output
// - chain starts at top-side first pad by input, ends at left-side top pad
// - only user pads get cells; config clock, done and test pins excluded
// - test logic active before configuration; afterwards a control bit decides
// - unused after configuration: test pins user io, output tristated or readback
// - no identification register exists among the data registers
// - sixteen controller states, next state chosen from mode-select each test clock
// - reprogram pin and power-up clear force the test logic reset state
// - outputs instruction/data select and a separate test output enable
// - each pad cell: data cell and direction cell, shift stage feeding hold stage
// - direction signal picks capture: low takes pad input, high takes functional output
// - mode high in external test drives scan data, else functional data to pads
// - inputs sampled on rising test clock, test output changes on falling edge
// - hold stage presents new pad values on falling test clock edge
// - capture loads, shift moves bits through, update loads instruction or hold stage
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module bst_tap #(
	parameter int NUM_PADS = 8
) (
	// clock and reset
	input  wire logic                   mclk,
	input  wire logic                   rst,
	// test port pins
	input  wire logic                   tck,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	output logic                        tdo,
	output logic                        tdo_oe,
	input  wire logic                   reprogram_pin,
	output logic                        test_pins_user_io,
	// io pads, index 0 is top_side_first_io, last is left_side_top_io
	input  wire logic [NUM_PADS-1:0]    pad_in,
	output logic      [NUM_PADS-1:0]    pad_out,
	output logic      [NUM_PADS-1:0]    pad_oe,
	input  wire logic [NUM_PADS-1:0]    func_out,
	input  wire logic [NUM_PADS-1:0]    pad_tristate_value,
	output logic      [NUM_PADS-1:0]    pad_to_core,
	// controller indications
	output logic                        select_ir,
	output logic                        test_logic_reset,
	// internal scan chains and configuration engine
	output bst_pkg::bst_chain_t         chain_ctl,
	input  wire logic                   logic_scan_chain_one,
	input  wire logic                   logic_scan_chain_two,
	output bst_pkg::bst_cfg_t           cfg_ctl,
	input  wire logic                   readback_data,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (NUM_PADS < 1 || NUM_PADS > 1024) begin : g_bad_pads
		$error("bst_tap: NUM_PADS must be 1..1024");
	end

	localparam int BSR_W = 2 * NUM_PADS;

	function automatic bst_pkg::bst_state_t tap_next(input bst_pkg::bst_state_t s, input logic m);
		bst_pkg::bst_state_t n;
		n = bst_pkg::TLR;
		case (s)
			bst_pkg::TLR:    n = m ? bst_pkg::TLR    : bst_pkg::RTI;
			bst_pkg::RTI:    n = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_DR: n = m ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
			bst_pkg::CAP_DR: n = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::SH_DR:  n = m ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
			bst_pkg::EX1_DR: n = m ? bst_pkg::UPD_DR : bst_pkg::PA_DR;
			bst_pkg::PA_DR:  n = m ? bst_pkg::EX2_DR : bst_pkg::PA_DR;
			bst_pkg::EX2_DR: n = m ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
			bst_pkg::UPD_DR: n = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
			bst_pkg::SEL_IR: n = m ? bst_pkg::TLR    : bst_pkg::CAP_IR;
			bst_pkg::CAP_IR: n = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::SH_IR:  n = m ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
			bst_pkg::EX1_IR: n = m ? bst_pkg::UPD_IR : bst_pkg::PA_IR;
			bst_pkg::PA_IR:  n = m ? bst_pkg::EX2_IR : bst_pkg::PA_IR;
			bst_pkg::EX2_IR: n = m ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
			bst_pkg::UPD_IR: n = m ? bst_pkg::SEL_DR : bst_pkg::RTI;
			default:         n = bst_pkg::TLR;
		endcase
		return n;
	endfunction : tap_next

	function automatic logic is_bypass(input logic [2:0] c);
		return (c == bst_pkg::IR_BYPASS) || (c == bst_pkg::IR_RESERVED);
	endfunction : is_bypass

	function automatic logic is_bsr(input logic [2:0] c);
		return (c == bst_pkg::IR_EXTEST) || (c == bst_pkg::IR_SAMPLE);
	endfunction : is_bsr

	// ----------------------------------------------------------------
	// pin synchronisers and test clock edges
	// ----------------------------------------------------------------
	logic [1:0]          tck_sync_r;
	logic [1:0]          tms_sync_r;
	logic [1:0]          tdi_sync_r;
	logic [1:0]          rpg_sync_r;
	logic [NUM_PADS-1:0] pin_a_r;
	logic [NUM_PADS-1:0] pin_b_r;
	logic                tck_d_r;
	logic                rise;
	logic                fall;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tck_sync_r <= 2'h0;
			tms_sync_r <= 2'h3;
			tdi_sync_r <= 2'h3;
			rpg_sync_r <= 2'h0;
			pin_a_r    <= '0;
			pin_b_r    <= '0;
			tck_d_r    <= 1'b0;
		end else begin
			tck_sync_r <= {tck_sync_r[0], tck};
			tms_sync_r <= {tms_sync_r[0], tms};
			tdi_sync_r <= {tdi_sync_r[0], tdi};
			rpg_sync_r <= {rpg_sync_r[0], reprogram_pin};
			pin_a_r    <= pad_in;
			pin_b_r    <= pin_a_r;
			tck_d_r    <= tck_sync_r[1];
		end
	end

	assign rise = tck_sync_r[1] & ~tck_d_r;
	assign fall = ~tck_sync_r[1] & tck_d_r;

	// ----------------------------------------------------------------
	// apb control / status
	// ----------------------------------------------------------------
	logic [2:0] ctrl_r;
	logic       active;
	logic       apb_acc;

	assign apb_acc = psel & penable & pready;

	assign active = ~ctrl_r[bst_pkg::CTRL_CFG_DONE] | ctrl_r[bst_pkg::CTRL_KEEP_SCAN];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_r <= bst_pkg::CTRL_RESET;
		end else if (apb_acc && pwrite && paddr == bst_pkg::ADDR_CTRL) begin
			ctrl_r <= pwdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	bst_pkg::bst_state_t state_r;
	logic                rst_test;

	assign rst_test = rpg_sync_r[1] | ~active;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_r <= bst_pkg::TLR;
		end else if (rst_test) begin
			state_r <= bst_pkg::TLR;
		end else if (rise) begin
			state_r <= tap_next(state_r, tms_sync_r[1]);
		end
	end

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	logic [2:0] ir_sh_r;
	logic [2:0] ir_r;
	logic       mode;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ir_sh_r <= bst_pkg::IR_BYPASS;
			ir_r    <= bst_pkg::IR_BYPASS;
		end else if (rst_test || (rise && state_r == bst_pkg::TLR)) begin
			ir_r    <= bst_pkg::IR_BYPASS;
		end else if (rise) begin
			case (state_r)
				bst_pkg::CAP_IR: ir_sh_r <= bst_pkg::IR_CAPTURE_VAL;
				bst_pkg::SH_IR:  ir_sh_r <= {tdi_sync_r[1], ir_sh_r[2:1]};
				bst_pkg::UPD_IR: ir_r    <= ir_sh_r;
				default:         ir_r    <= ir_r;
			endcase
		end
	end

	assign mode = (ir_r == bst_pkg::IR_EXTEST);

	// ----------------------------------------------------------------
	// boundary register and bypass
	// ----------------------------------------------------------------
	// pad i: data cell at bit 2i, direction cell at bit 2i+1; bit 0 faces tdi
	logic [BSR_W-1:0]    bsr_sh_r;
	logic [NUM_PADS-1:0] hold_data_r;
	logic [NUM_PADS-1:0] hold_dir_r;
	logic [NUM_PADS-1:0] direction_out_high_in_low;
	logic [BSR_W-1:0]    bsr_cap;
	logic                byp_r;

	always_comb begin
		bsr_cap = '0;
		for (int i = 0; i < NUM_PADS; i++) begin
			direction_out_high_in_low[i] = mode ? hold_dir_r[i] : pad_tristate_value[i];
			bsr_cap[2*i]   = direction_out_high_in_low[i] ? func_out[i] : pin_b_r[i];
			bsr_cap[2*i+1] = direction_out_high_in_low[i];
		end
	end

	// chain order, shift stage, capture and shift
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bsr_sh_r <= '0;
		end else if (rise && is_bsr(ir_r) && state_r == bst_pkg::CAP_DR) begin
			bsr_sh_r <= bsr_cap;
		end else if (rise && is_bsr(ir_r) && state_r == bst_pkg::SH_DR) begin
			bsr_sh_r <= {bsr_sh_r[BSR_W-2:0], tdi_sync_r[1]};
		end
	end

	// hold stage loads on falling edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_data_r <= '0;
			hold_dir_r  <= '0;
		end else if (fall && is_bsr(ir_r) && state_r == bst_pkg::UPD_DR) begin
			for (int i = 0; i < NUM_PADS; i++) begin
				hold_data_r[i] <= bsr_sh_r[2*i];
				hold_dir_r[i]  <= bsr_sh_r[2*i+1];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			byp_r <= 1'b0;
		end else if (rise && is_bypass(ir_r) && state_r == bst_pkg::CAP_DR) begin
			byp_r <= 1'b0;
		end else if (rise && is_bypass(ir_r) && state_r == bst_pkg::SH_DR) begin
			byp_r <= tdi_sync_r[1];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_out     <= '0;
			pad_oe      <= '0;
			pad_to_core <= '0;
		end else begin
			pad_out     <= mode ? hold_data_r : func_out;
			pad_oe      <= mode ? hold_dir_r : pad_tristate_value;
			pad_to_core <= pin_b_r;
		end
	end

	// ----------------------------------------------------------------
	// internal chains and configuration paths
	// ----------------------------------------------------------------
	logic in_dr_sh;

	assign in_dr_sh = rise && state_r == bst_pkg::SH_DR;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			chain_ctl <= '0;
		end else begin
			chain_ctl.sel_one <= (ir_r == bst_pkg::IR_CHAIN_ONE);
			chain_ctl.sel_two <= (ir_r == bst_pkg::IR_CHAIN_TWO);
			chain_ctl.capture <= rise && state_r == bst_pkg::CAP_DR;
			chain_ctl.shift   <= in_dr_sh;
			chain_ctl.update  <= rise && state_r == bst_pkg::UPD_DR;
			chain_ctl.si      <= tdi_sync_r[1];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_ctl <= '0;
		end else begin
			cfg_ctl.wr_valid <= in_dr_sh && ir_r == bst_pkg::IR_CFG_WRITE;
			cfg_ctl.wr_data  <= tdi_sync_r[1];
			cfg_ctl.rb_shift <= in_dr_sh && ir_r == bst_pkg::IR_READBACK
			                    && ctrl_r[bst_pkg::CTRL_CFG_DONE];
		end
	end

	// ----------------------------------------------------------------
	// test data output
	// ----------------------------------------------------------------
	logic dr_so;

	// no identification path: unlisted codes fall to bypass
	always_comb begin
		case (ir_r)
			bst_pkg::IR_EXTEST,
			bst_pkg::IR_SAMPLE:    dr_so = bsr_sh_r[BSR_W-1];
			bst_pkg::IR_CHAIN_ONE: dr_so = logic_scan_chain_one;
			bst_pkg::IR_CHAIN_TWO: dr_so = logic_scan_chain_two;
			bst_pkg::IR_READBACK:  dr_so = ctrl_r[bst_pkg::CTRL_CFG_DONE] & readback_data;
			bst_pkg::IR_CFG_WRITE: dr_so = 1'b0;
			default:               dr_so = byp_r;
		endcase
	end

	// while active: output on falling edge, enable only while shifting
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tdo    <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (!active) begin
			// readback or tristate once scan is released
			tdo    <= readback_data;
			tdo_oe <= ctrl_r[bst_pkg::CTRL_RB_TDO];
		end else if (fall) begin
			tdo    <= (state_r == bst_pkg::SH_IR) ? ir_sh_r[0] : dr_so;
			tdo_oe <= (state_r == bst_pkg::SH_IR) || (state_r == bst_pkg::SH_DR);
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			select_ir         <= 1'b0;
			test_logic_reset  <= 1'b1;
			test_pins_user_io <= 1'b0;
		end else begin
			select_ir         <= (state_r >= bst_pkg::SEL_IR);
			test_logic_reset  <= (state_r == bst_pkg::TLR);
			test_pins_user_io <= ~active;
		end
	end

	// ----------------------------------------------------------------
	// apb answer: one wait state, registered data
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & penable & ~pready;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (psel && penable && !pready) begin
				case (paddr)
					bst_pkg::ADDR_CTRL: prdata[2:0] <= ctrl_r;
					bst_pkg::ADDR_STATUS: begin
						if (!pwrite) begin
							prdata[bst_pkg::STAT_STATE_LSB +: 4] <= state_r;
							prdata[bst_pkg::STAT_IR_LSB +: 3]    <= ir_r;
							prdata[bst_pkg::STAT_TDO_OE]         <= tdo_oe;
							prdata[bst_pkg::STAT_ACTIVE]         <= active;
							prdata[bst_pkg::STAT_MODE]           <= mode;
						end
					end
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : bst_tap

// ---- include/bst_pkg.sv ----
// bst_pkg: constants, types and register map of the boundary-scan test port.
// assumes: a single system clock (mclk) samples every test pin; software owns the apb side.
package bst_pkg;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [2:0] IR_EXTEST    = 3'h0;
	localparam logic [2:0] IR_CHAIN_ONE = 3'h1;
	localparam logic [2:0] IR_CFG_WRITE = 3'h2;
	localparam logic [2:0] IR_RESERVED  = 3'h3;
	localparam logic [2:0] IR_SAMPLE    = 3'h4;
	localparam logic [2:0] IR_CHAIN_TWO = 3'h5;
	localparam logic [2:0] IR_READBACK  = 3'h6;
	localparam logic [2:0] IR_BYPASS    = 3'h7;
	// value parallel-loaded into the instruction shifter at capture
	localparam logic [2:0] IR_CAPTURE_VAL = 3'h1;
	localparam int         IR_W           = 3;

	// ----------------------------------------------------------------
	// apb register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam int CTRL_CFG_DONE  = 0;
	localparam int CTRL_KEEP_SCAN = 1;
	localparam int CTRL_RB_TDO    = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_IR_LSB    = 4;
	localparam int STAT_TDO_OE    = 8;
	localparam int STAT_ACTIVE    = 9;
	localparam int STAT_MODE      = 10;

	// ----------------------------------------------------------------
	// controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
		SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
	} bst_state_t;

	// ----------------------------------------------------------------
	// carriers to the internal logic
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sel_one;
		logic sel_two;
		logic capture;
		logic shift;
		logic update;
		logic si;
	} bst_chain_t;

	typedef struct packed {
		logic wr_valid;
		logic wr_data;
		logic rb_shift;
	} bst_cfg_t;

endpackage : bst_pkg

// ---- dv/bst_tap_assertions.sv ----
// bst_tap_assertions: timing checks on the scan port and apb pins of bst_tap.
// assumes: bound to bst_tap; tck is far slower than mclk.
`timescale 1ns/10ps
module bst_tap_assertions (
	// clock and reset
	input wire logic                mclk,
	input wire logic                rst,
	// test port
	input wire logic                tck,
	input wire logic                tdo,
	input wire logic                tdo_oe,
	input wire logic                reprogram_pin,
	input wire logic                test_pins_user_io,
	input wire logic                select_ir,
	input wire logic                test_logic_reset,
	input wire bst_pkg::bst_chain_t chain_ctl,
	input wire bst_pkg::bst_cfg_t   cfg_ctl,
	// apb
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pready
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----------------
	// checks
	// ----------------
	AST_REPROG_RESET: assert property (reprogram_pin [*6] |-> test_logic_reset)
		else $error("reprogram left reset state");
	// mode switches are skipped: tdo then follows the readback path
	AST_TDO_ON_FALL: assert property (!test_pins_user_io && !$past(test_pins_user_io) && $changed(tdo)
		|-> !tck && !$past(tck)) else $error("tdo moved while tck high");
	AST_OE_ON_FALL: assert property (!test_pins_user_io && !$past(test_pins_user_io) && $changed(tdo_oe)
		|-> !tck) else $error("tdo_oe moved while tck high");
	AST_SELECT_IR: assert property (test_logic_reset |-> !select_ir)
		else $error("select_ir high in reset state");
	AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	AST_APB_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_CHAIN_EXCL: assert property (!(chain_ctl.sel_one && chain_ctl.sel_two))
		else $error("both scan chains selected");
	AST_WR_PULSE: assert property (cfg_ctl.wr_valid |=> !cfg_ctl.wr_valid)
		else $error("config write pulse too long");
	AST_USER_IO: assert property (test_pins_user_io && $past(test_pins_user_io, 2) |-> test_logic_reset)
		else $error("inactive scan not in reset");
endmodule : bst_tap_assertions

// ---- dv/bst_host_model.sv ----
// bst_host_model: test host that paces tck and drives tms/tdi.
// assumes: tck idles low between frames; tdo settles within half a tck.
`timescale 1ns/10ps
module bst_host_model (
	// test pins
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	initial begin
		tck = 1'h0;
		tms = 1'h1;
		tdi = 1'h0;
	end
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#62.5;
		// a released tdo floats: show the inverse so a late enable is caught
		o = tdo_oe ? tdo : ~tdo;
		tck = 1'h1;
		#62.5;
		tck = 1'h0;
	endtask : step
	task automatic idle;
		logic o;
		for (int k = 0; k < 6; k++) step(k < 5, ~tdi, o);
	endtask : idle
	// one scan from idle back to idle; dout[k] is the k-th bit out
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic o;
		dout = 32'h0;
		step(1'h1, ~tdi, o);
		if (ir) step(1'h1, ~tdi, o);
		step(1'h0, ~tdi, o);
		step(1'h0, ~tdi, o);
		for (int k = 0; k < n; k++) step(k == n - 1, din[k], dout[k]);
		step(1'h1, ~tdi, o);
		step(1'h0, ~tdi, o);
	endtask : scan
endmodule : bst_host_model

// ---- dv/testbench.sv ----
// testbench: drives bst_tap through its scan port, pads and apb.
// assumes: host model paces tck; eight pads.
`timescale 1ns/10ps
module testbench;
	localparam int NP = 8;
	logic                mclk, rst, tck, tms, tdi, tdo, tdo_oe, reprogram_pin, test_pins_user_io;
	logic                select_ir, test_logic_reset, logic_scan_chain_one, logic_scan_chain_two, readback_data;
	logic [NP-1:0]       pad_in, pad_out, pad_oe, func_out, pad_tristate_value, pad_to_core;
	bst_pkg::bst_chain_t chain_ctl;
	bst_pkg::bst_cfg_t   cfg_ctl;
	logic                psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, rd, so, wr_bits;
	int                  failures, total_checks, wr_cnt, rb_cnt, ch_cnt;

	bst_tap #(.NUM_PADS(NP)) uut (.mclk, .rst, .tck, .tms, .tdi, .tdo, .tdo_oe, .reprogram_pin,
		.test_pins_user_io, .pad_in, .pad_out, .pad_oe, .func_out, .pad_tristate_value, .pad_to_core,
		.select_ir, .test_logic_reset, .chain_ctl, .logic_scan_chain_one, .logic_scan_chain_two, .cfg_ctl,
		.readback_data, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	bst_host_model host (.tck, .tms, .tdi, .tdo, .tdo_oe);

	always #5 mclk = ~mclk;
	// pulse counters on the strobes towards the core
	always @(posedge mclk) begin
		if (cfg_ctl.wr_valid === 1'h1) begin
			wr_cnt++;
			wr_bits = {wr_bits[30:0], cfg_ctl.wr_data};
		end
		if (cfg_ctl.rb_shift === 1'h1) rb_cnt++;
		if (chain_ctl.shift === 1'h1 && chain_ctl.sel_one === 1'h1) ch_cnt++;
	end

	// ----------------
	// shared tasks
	// ----------------
	task automatic complete_run;
		if (failures == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			failures++;
			complete_run();
		end
	endtask : apb

	// ----------------
	// scenarios
	// ----------------
	task automatic t_reset;
		chk(test_logic_reset, 1'h1, "reset state");
		chk(select_ir, 1'h0, "select in reset");
		apb(1'h0, bst_pkg::ADDR_STATUS, 32'h0);
		chk(rd[6:0], 7'h70, "reset instr");
		apb(1'h0, 8'h08, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000, "unmapped");
	endtask : t_reset
	task automatic t_codes;
		for (int c = 0; c < 8; c++) begin
			host.scan(1'h1, 3, c, so);
			chk(so[2:0], bst_pkg::IR_CAPTURE_VAL, "ir capture");
			apb(1'h0, bst_pkg::ADDR_STATUS, 32'h0);
			chk(rd[6:4], c[2:0], "instr");
			chk(rd[10], c == 0, "mode");
			chk({chain_ctl.sel_one, chain_ctl.sel_two}, {c == 1, c == 5}, "chain sel");
		end
		for (int j = 0; j < 2; j++) begin
			host.scan(1'h1, 3, j ? 32'h3 : 32'h7, so);
			host.scan(1'h0, 4, 32'hd, so);
			chk(so[3:0], 4'ha, "bypass");
		end
	endtask : t_codes
	task automatic t_pads;
		logic [15:0] b;
		logic [31:0] v;
		@(posedge mclk);
		pad_in <= 8'h5a;
		func_out <= 8'h33;
		pad_tristate_value <= 8'h0f;
		host.scan(1'h1, 3, 32'h4, so);
		host.scan(1'h0, 16, 32'h0, so);
		for (int i = 0; i < NP; i++) begin
			chk(so[15-2*i], pad_tristate_value[i] ? func_out[i] : pad_in[i], "data cell");
			chk(so[14-2*i], pad_tristate_value[i], "dir cell");
		end
		chk({pad_oe, pad_out, pad_to_core}, {pad_tristate_value, func_out, pad_in}, "normal pads");
		b = 16'h9c5a;
		v = 32'h0;
		for (int k = 0; k < 16; k++) v[k] = b[15-k];
		host.scan(1'h1, 3, 32'h0, so);
		host.scan(1'h0, 16, v, so);
		for (int i = 0; i < NP; i++) chk({pad_oe[i], pad_out[i]}, b[2*i+:2], "extest pad");
		host.scan(1'h0, 16, v, so);
		for (int i = 0; i < NP; i++) begin
			if (!b[2*i+1]) chk(so[15-2*i], pad_in[i], "extest in");
			chk(so[14-2*i], b[2*i+1], "extest dir");
		end
	endtask : t_pads
	task automatic t_paths;
		@(posedge mclk);
		logic_scan_chain_one <= 1'h1;
		readback_data <= 1'h1;
		host.scan(1'h1, 3, 32'h1, so);
		ch_cnt = 0;
		host.scan(1'h0, 3, 32'h0, so);
		chk(so[2:0], 3'h7, "chain one");
		chk(ch_cnt, 32'h3, "chain shifts");
		host.scan(1'h1, 3, 32'h5, so);
		host.scan(1'h0, 3, 32'h7, so);
		chk(so[2:0], 3'h0, "chain two");
		host.scan(1'h1, 3, 32'h2, so);
		wr_cnt = 0;
		host.scan(1'h0, 5, 32'h13, so);
		chk(wr_cnt, 32'h5, "cfg bits");
		chk(wr_bits[4:0], 5'h19, "cfg data");
		host.scan(1'h1, 3, 32'h6, so);
		rb_cnt = 0;
		host.scan(1'h0, 3, 32'h0, so);
		chk(so[2:0], 3'h0, "readback early");
		chk(rb_cnt, 32'h0, "readback idle");
		apb(1'h1, bst_pkg::ADDR_CTRL, 32'h3);
		host.scan(1'h0, 3, 32'h0, so);
		chk(so[2:0], 3'h7, "readback");
		chk(rb_cnt, 32'h3, "readback shifts");
	endtask : t_paths
	task automatic t_inactive;
		apb(1'h1, bst_pkg::ADDR_CTRL, 32'h5);
		repeat (4) @(posedge mclk);
		chk({test_pins_user_io, test_logic_reset, tdo_oe, tdo}, 4'hf, "inactive");
		apb(1'h1, bst_pkg::ADDR_CTRL, 32'h1);
		repeat (4) @(posedge mclk);
		chk(tdo_oe, 1'h0, "tdo off");
		apb(1'h1, bst_pkg::ADDR_CTRL, 32'h3);
		host.idle();
		chk(test_pins_user_io, 1'h0, "active again");
		host.scan(1'h1, 3, 32'h0, so);
		@(posedge mclk);
		reprogram_pin <= 1'h1;
		repeat (8) @(posedge mclk);
		chk(test_logic_reset, 1'h1, "reprogram");
		reprogram_pin <= 1'h0;
		apb(1'h0, bst_pkg::ADDR_STATUS, 32'h0);
		chk(rd[6:0], 7'h70, "reprogram instr");
	endtask : t_inactive

	initial begin
		{mclk, reprogram_pin, logic_scan_chain_one, logic_scan_chain_two, readback_data} = 5'h0;
		{pad_in, func_out, pad_tristate_value} = 24'h0;
		{psel, penable, pwrite, paddr, pwdata} = 43'h0;
		{failures, total_checks, wr_cnt} = 96'h0;
		rst = 1'h1;
		repeat (4) @(posedge mclk);
		rst <= 1'h0;
		t_reset();
		host.idle();
		t_codes();
		t_pads();
		t_paths();
		t_inactive();
		complete_run();
	end
	initial begin
		repeat (90000) @(posedge mclk);
		failures++;
		complete_run();
	end
endmodule : testbench

bind bst_tap bst_tap_assertions chk_i (.mclk, .rst, .tck, .tdo, .tdo_oe, .reprogram_pin, .test_pins_user_io,
	.select_ir, .test_logic_reset, .chain_ctl, .cfg_ctl, .psel, .penable, .pready);
